/* File: qtd_top.sv */
// Queue status pins and background debug entry control
module qtd_top (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic [1:0]  cpu_move_i,
	input  wire logic [1:0]  cpu_start_i,
	input  wire logic        cpu_instr_done_i,
	input  wire logic [15:0] cpu_bus_data_i,
	input  wire logic [15:0] cpu_addr_i,
	input  wire logic        cpu_dead_cycle_i,
	input  wire logic        instr_boundary_i,
	input  wire logic        tag_hit_i,
	input  wire logic        enter_debug_instruction_i,
	input  wire logic        exit_debug_i,
	input  wire logic        debug_wire_pin_i,
	output logic             debug_wire_pin_o,
	output logic             debug_wire_pin_oe_o,
	output logic             bus_phase_clock_o,
	output logic      [1:0]  queue_status_pins_o,
	output logic      [7:0]  opcode_o,
	output logic             queue_starved_o,
	output logic             firmware_enable_bit_o,
	output logic             background_debug_state_o,
	output logic             firmware_cmd_ok_o,
	output logic             debug_map_sel_o,
	output logic             tag_hold_o,
	output logic             cpu_hold_o,
	output logic             freeze_cpu_o
);
	typedef enum logic [2:0] {CMD_IDLE, CMD_ADDR_HI, CMD_ADDR_LO, CMD_DATA_HI,
	                          CMD_DATA_LO, CMD_EXEC} qtd_cmd_t;
	typedef enum logic [1:0] {ACT_IDLE, ACT_PEND, ACT_DENY, ACT_ON} qtd_act_t;

	// ----------------------------------------------------------------
	// Bus phase clock divider
	// ----------------------------------------------------------------
	logic [1:0]  e_cnt;
	logic        e_level;
	wire         e_wrap  = (e_cnt == qtd_pkg::E_HALF_CYC - 2'h1);
	wire         e_rise  = e_wrap && !e_level;
	wire         e_fall  = e_wrap && e_level;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			e_cnt   <= 2'h0;
			e_level <= 1'b0;
		end else begin
			e_cnt   <= e_wrap ? 2'h0 : e_cnt + 2'h1;
			e_level <= e_wrap ? !e_level : e_level;
		end
	end
	assign bus_phase_clock_o = e_level;

	// ----------------------------------------------------------------
	// Queue status multiplexing
	// ----------------------------------------------------------------
	logic [1:0]  move_held;
	logic [15:0] data_held;
	logic        instr_busy;
	wire         is_instr = (cpu_start_i == qtd_pkg::START_EVEN) ||
	                        (cpu_start_i == qtd_pkg::START_ODD);
	// hold off a start while the last one runs
	wire  [1:0]  start_gated = (instr_busy && is_instr) ? qtd_pkg::START_NONE : cpu_start_i;
	logic [1:0]  start_held;
	// movement tied to data seen at this falling edge
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			move_held <= qtd_pkg::MOVE_NONE;
			data_held <= 16'h0000;
		end else if (e_fall) begin
			move_held <= cpu_move_i;
			data_held <= cpu_bus_data_i;
		end
	end
	// busy from a start until the CPU reports completion
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			instr_busy <= 1'b0;
			start_held <= qtd_pkg::START_NONE;
		end else begin
			if (e_rise) begin
				start_held <= start_gated;
			end
			if (e_rise && (start_gated == qtd_pkg::START_EVEN ||
			               start_gated == qtd_pkg::START_ODD)) begin
				instr_busy <= 1'b1;
			end else if (cpu_instr_done_i) begin
				instr_busy <= 1'b0;
			end
		end
	end
	// Pins change at the opposite edge so each code is settled when sampled
	// refresh on every half period
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			queue_status_pins_o <= qtd_pkg::MOVE_NONE;
		end else if (e_fall) begin
			// movement code for the low phase
			queue_status_pins_o <= cpu_move_i;
		end else if (e_rise) begin
			// start code for the high phase
			queue_status_pins_o <= start_gated;
		end
	end

	qtd_queue u_queue (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.move_en_i  (e_rise),
		.move_i     (move_held),
		.bus_data_i (data_held),
		.start_en_i (e_fall),
		.start_i    (start_held),
		.opcode_o   (opcode_o),
		.starved_o  (queue_starved_o)
	);

	// ----------------------------------------------------------------
	// Debug wire receiver and command decode
	// ----------------------------------------------------------------
	logic [7:0]  rx_byte;
	logic        rx_valid;
	logic        rx_timeout;
	qtd_cmd_t    cmd_state;
	logic [15:0] cmd_addr;
	logic [15:0] cmd_data;
	logic [7:0]  steal_cnt;
	logic        fw_write_done;
	qtd_wire_rx u_rx (
		.clk_sys_i    (clk_sys_i),
		.rst_i        (rst_i),
		.wire_i       (debug_wire_pin_i),
		.byte_o       (rx_byte),
		.byte_valid_o (rx_valid),
		.timeout_o    (rx_timeout)
	);
	// Receive only: the target never drives the wire here
	always_ff @(posedge clk_sys_i) begin
		debug_wire_pin_o    <= 1'b0;
		debug_wire_pin_oe_o <= 1'b0;
	end
	wire enter_debug_instruction_cmd  = rx_valid && (cmd_state == CMD_IDLE) &&
	                 (rx_byte == qtd_pkg::CMD_BACKGROUND);
	wire steal_now = (steal_cnt == qtd_pkg::STEAL_LIMIT_CYC);
	// free cycle first, steal after the wait limit
	wire exec_go   = (cmd_state == CMD_EXEC) && (cpu_dead_cycle_i || freeze_cpu_o);
	wire wr_byte   = cmd_addr[0] ? cmd_data[qtd_pkg::FW_ENABLE_BIT] :
	                 cmd_data[qtd_pkg::FW_ENABLE_BIT + qtd_pkg::BYTE_W];
	// Command sequencer; a link time-out clears any partial command
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || rx_timeout) begin
			cmd_state <= CMD_IDLE;
			cmd_addr  <= 16'h0000;
			cmd_data  <= 16'h0000;
		end else begin
			unique case (cmd_state)
				CMD_IDLE: begin
					if (rx_valid && rx_byte == qtd_pkg::CMD_WRITE_MAP_BYTE) begin
						cmd_state <= CMD_ADDR_HI;
					end
				end
				CMD_ADDR_HI: begin
					if (rx_valid) begin
						cmd_addr[15:8] <= rx_byte;
						cmd_state      <= CMD_ADDR_LO;
					end
				end
				CMD_ADDR_LO: begin
					if (rx_valid) begin
						cmd_addr[7:0] <= rx_byte;
						cmd_state     <= CMD_DATA_HI;
					end
				end
				CMD_DATA_HI: begin
					if (rx_valid) begin
						cmd_data[15:8] <= rx_byte;
						cmd_state      <= CMD_DATA_LO;
					end
				end
				CMD_DATA_LO: begin
					if (rx_valid) begin
						cmd_data[7:0] <= rx_byte;
						cmd_state     <= CMD_EXEC;
					end
				end
				CMD_EXEC: begin
					if (exec_go) begin
						cmd_state <= CMD_IDLE;
					end
				end
			endcase
		end
	end
	// Cycle stealing: freeze the CPU for one cycle if no dead cycle shows up
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || cmd_state != CMD_EXEC || exec_go) begin
			steal_cnt    <= 8'h00;
			freeze_cpu_o <= 1'b0;
		end else begin
			steal_cnt    <= steal_now ? steal_cnt : steal_cnt + 8'h01;
			freeze_cpu_o <= steal_now && !cpu_dead_cycle_i;
		end
	end
	// firmware enable set by byte write at its address
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			firmware_enable_bit_o <= 1'b0;
			fw_write_done         <= 1'b0;
		end else begin
			fw_write_done <= exec_go && (cmd_addr == qtd_pkg::FW_ENABLE_ADDR);
			if (exec_go && cmd_addr == qtd_pkg::FW_ENABLE_ADDR) begin
				firmware_enable_bit_o <= wr_byte;
			end
		end
	end

	// ----------------------------------------------------------------
	// Background mode activation; no operating mode input gates it
	// ----------------------------------------------------------------
	qtd_act_t    act_state;
	qtd_act_t    next_act;
	logic [3:0]  deny_cnt;
	wire         want_now = tag_hit_i || enter_debug_instruction_i;
	wire         deny_done = (deny_cnt == qtd_pkg::DENY_DELAY_CYC - 4'h1);
	always_comb begin
		next_act = act_state;
		unique case (act_state)
			ACT_IDLE: begin
				// disabled attempt goes to a short hold
				if ((want_now || enter_debug_instruction_cmd) && !firmware_enable_bit_o) begin
					next_act = ACT_DENY;
				end else if (want_now) begin
					// tag enters before the instruction runs
					next_act = ACT_ON;
				end else if (enter_debug_instruction_cmd) begin
					next_act = ACT_PEND;
				end
			end
			ACT_PEND: next_act = instr_boundary_i ? ACT_ON : ACT_PEND;
			ACT_DENY: next_act = deny_done ? ACT_IDLE : ACT_DENY;
			ACT_ON:   next_act = exit_debug_i ? ACT_IDLE : ACT_ON;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			act_state <= ACT_IDLE;
			deny_cnt  <= 4'h0;
		end else begin
			act_state <= next_act;
			deny_cnt  <= (act_state == ACT_DENY) ? deny_cnt + 4'h1 : 4'h0;
		end
	end
	// activation maps the debug page and sets background state
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			background_debug_state_o <= 1'b0;
			firmware_cmd_ok_o        <= 1'b0;
			debug_map_sel_o          <= 1'b0;
			tag_hold_o               <= 1'b0;
			cpu_hold_o               <= 1'b0;
		end else begin
			background_debug_state_o <= (next_act == ACT_ON);
			firmware_cmd_ok_o        <= (next_act == ACT_ON);
			// ROM visible only in background mode
			debug_map_sel_o          <= (next_act == ACT_ON) &&
			                            (cpu_addr_i[15:8] == qtd_pkg::DEBUG_MAP_PAGE);
			tag_hold_o               <= tag_hit_i && (act_state == ACT_IDLE) &&
			                            firmware_enable_bit_o;
			cpu_hold_o               <= (next_act == ACT_DENY);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	pins_move_a: assert property ($fell(bus_phase_clock_o) |->
		queue_status_pins_o == move_held) else $error("movement code wrong");
	pins_start_a: assert property ($rose(bus_phase_clock_o) |->
		queue_status_pins_o == start_held) else $error("start code wrong");
	pins_stable_a: assert property (!$changed(bus_phase_clock_o) |->
		$stable(queue_status_pins_o)) else $error("pins moved mid phase");
	deny_hold_a: assert property ($rose(cpu_hold_o) |->
		cpu_hold_o [*8] ##1 !cpu_hold_o) else $error("deny delay wrong");
	enter_debug_instruction_gate_a: assert property (enter_debug_instruction_cmd && !firmware_enable_bit_o |->
		##1 !background_debug_state_o [*3]) else $error("entered while disabled");
	boundary_a: assert property (act_state == ACT_PEND && instr_boundary_i |->
		##1 background_debug_state_o) else $error("no entry at boundary");
	tag_entry_a: assert property (tag_hit_i && act_state == ACT_IDLE &&
		firmware_enable_bit_o |=> background_debug_state_o && tag_hold_o)
		else $error("tag entry late");
	rom_map_a: assert property (debug_map_sel_o |->
		background_debug_state_o && $past(cpu_addr_i[15:8]) == qtd_pkg::DEBUG_MAP_PAGE)
		else $error("debug map outside background");
	fw_cmd_a: assert property (firmware_cmd_ok_o |-> background_debug_state_o)
		else $error("firmware command outside background");
	fw_write_a: assert property (fw_write_done |->
		firmware_enable_bit_o == $past(wr_byte)) else $error("enable bit not written");
	steal_a: assert property (cmd_state == CMD_EXEC && !cpu_dead_cycle_i |->
		##[1:130] cmd_state != CMD_EXEC) else $error("no cycle stolen");
	busy_a: assert property (instr_busy && !cpu_instr_done_i && e_rise |=>
		start_held != qtd_pkg::START_EVEN && start_held != qtd_pkg::START_ODD)
		else $error("start during busy");

	enter_c: cover property (act_state == ACT_PEND ##[1:20] background_debug_state_o);
	deny_c: cover property ($rose(cpu_hold_o));
	steal_c: cover property (freeze_cpu_o);
	starve_c: cover property ($rose(queue_starved_o));
endmodule

/* File: qtd_pkg.sv */
// Constants shared by the queue tracking and debug entry block
package qtd_pkg;
	// ----------------------------------------------------------------
	// Queue data-movement and execution-start codes
	// ----------------------------------------------------------------
	localparam logic [1:0] MOVE_NONE     = 2'h0;
	localparam logic [1:0] MOVE_LATCH    = 2'h1;
	localparam logic [1:0] MOVE_ADV_BUS  = 2'h2;
	localparam logic [1:0] MOVE_ADV_LAT  = 2'h3;
	localparam logic [1:0] START_NONE    = 2'h0;
	localparam logic [1:0] START_INTR    = 2'h1;
	localparam logic [1:0] START_EVEN    = 2'h2;
	localparam logic [1:0] START_ODD     = 2'h3;
	// ----------------------------------------------------------------
	// Queue geometry
	// ----------------------------------------------------------------
	localparam int         WORD_W        = 16;
	localparam int         BYTE_W        = 8;
	localparam logic [2:0] MIN_QUEUE_BYTES = 3'h3;
	// ----------------------------------------------------------------
	// Debug link and map
	// ----------------------------------------------------------------
	localparam logic [7:0]  CMD_BACKGROUND = 8'h90;
	localparam logic [7:0]  CMD_WRITE_MAP_BYTE = 8'hC4;
	localparam logic [15:0] FW_ENABLE_ADDR = 16'hFF01;
	localparam logic [7:0]  DEBUG_MAP_PAGE = 8'hFF;
	localparam int          FW_ENABLE_BIT  = 7;
	localparam logic [3:0]  BIT_SAMPLE_CYC = 4'hA;
	localparam logic [9:0]  BIT_TIMEOUT_CYC = 10'h200;
	localparam logic [7:0]  STEAL_LIMIT_CYC = 8'h80;
	localparam logic [3:0]  DENY_DELAY_CYC = 4'h8;
	localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
	// ----------------------------------------------------------------
	// Bus phase clock: system cycles per half period
	// ----------------------------------------------------------------
	localparam logic [1:0]  E_HALF_CYC     = 2'h2;
endpackage

/* File: qtd_queue.sv */
// Two-stage instruction queue with holding latch
module qtd_queue (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        move_en_i,
	input  wire logic [1:0]  move_i,
	input  wire logic [15:0] bus_data_i,
	input  wire logic        start_en_i,
	input  wire logic [1:0]  start_i,
	output logic      [7:0]  opcode_o,
	output logic             starved_o
);
	logic [15:0] hold_latch;
	logic [15:0] stage1;
	logic [15:0] stage2;
	logic        v_latch;
	logic        v1;
	logic        v2;
	logic [2:0]  avail;
	wire         adv        = move_en_i && (move_i == qtd_pkg::MOVE_ADV_BUS ||
	                                        move_i == qtd_pkg::MOVE_ADV_LAT);
	wire  [15:0] fill_word  = (move_i == qtd_pkg::MOVE_ADV_LAT) ? hold_latch : bus_data_i;
	wire         fill_valid = (move_i == qtd_pkg::MOVE_ADV_LAT) ? v_latch : 1'b1;
	wire         odd_start  = (start_i == qtd_pkg::START_ODD);
	wire         instr_go   = start_en_i && (start_i == qtd_pkg::START_EVEN || odd_start);

	// Bytes left for the CPU from the opcode byte onward
	assign avail = {1'b0, v1, 1'b0} + (odd_start ? {2'h0, v2} : {1'b0, v2, 1'b0});

	// ----------------------------------------------------------------
	// Queue movement
	// ----------------------------------------------------------------
	// two stages plus latch
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			hold_latch <= 16'h0000;
			stage1     <= 16'h0000;
			stage2     <= 16'h0000;
			v_latch    <= 1'b0;
			v1         <= 1'b0;
			v2         <= 1'b0;
		end else if (move_en_i && move_i == qtd_pkg::MOVE_LATCH) begin
			hold_latch <= bus_data_i;
			v_latch    <= 1'b1;
		end else if (adv) begin
			stage2 <= stage1;
			v2     <= v1;
			stage1 <= fill_word;
			v1     <= fill_valid;
			if (move_i == qtd_pkg::MOVE_ADV_LAT) begin
				v_latch <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Opcode pick and starvation flag
	// ----------------------------------------------------------------
	// even high byte, odd low byte
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			opcode_o  <= 8'h00;
			starved_o <= 1'b0;
		end else if (instr_go) begin
			opcode_o  <= odd_start ? stage2[7:0] : stage2[15:8];
			starved_o <= (avail < qtd_pkg::MIN_QUEUE_BYTES);
		end
	end
endmodule

/* File: qtd_wire_rx.sv */
// Receiver for bytes sent by the host over the debug wire
module qtd_wire_rx (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       wire_i,
	output logic      [7:0] byte_o,
	output logic            byte_valid_o,
	output logic            timeout_o
);
	logic       sync1;
	logic       sync2;
	logic       sync3;
	logic       sampling;
	logic [3:0] sample_cnt;
	logic [3:0] bit_cnt;
	logic [9:0] idle_cnt;
	logic [7:0] shift;
	wire        fall      = sync3 && !sync2;
	wire        sample_now = sampling && (sample_cnt == qtd_pkg::BIT_SAMPLE_CYC);
	wire        last_bit  = (bit_cnt == qtd_pkg::BITS_PER_BYTE - 4'h1);
	wire        time_out  = (bit_cnt != 4'h0) && (idle_cnt == qtd_pkg::BIT_TIMEOUT_CYC);

	// Pin synchroniser, host edges are asynchronous
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			sync3 <= 1'b1;
		end else begin
			sync1 <= wire_i;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// ----------------------------------------------------------------
	// Bit timing: host falling edge opens each bit, MSB first
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || time_out) begin
			sampling     <= 1'b0;
			sample_cnt   <= 4'h0;
			bit_cnt      <= 4'h0;
			idle_cnt     <= 10'h000;
			shift        <= 8'h00;
			byte_valid_o <= 1'b0;
			byte_o       <= 8'h00;
			timeout_o    <= time_out;
		end else begin
			byte_valid_o <= 1'b0;
			timeout_o    <= 1'b0;
			idle_cnt     <= fall ? 10'h000 : idle_cnt + 10'h001;
			if (fall) begin
				sampling   <= 1'b1;
				sample_cnt <= 4'h1;
			end else if (sample_now) begin
				// bits arrive on the single wire
				sampling <= 1'b0;
				shift    <= {shift[6:0], sync2};
				bit_cnt  <= last_bit ? 4'h0 : bit_cnt + 4'h1;
				if (last_bit) begin
					byte_o       <= {shift[6:0], sync2};
					byte_valid_o <= 1'b1;
				end
			end else if (sampling) begin
				sample_cnt <= sample_cnt + 4'h1;
			end
		end
	end
endmodule

/* File: qtd_host_model.sv */
// Development host model driving the single debug wire
module qtd_host_model (
	input  wire logic clk_sys_i,
	output logic      wire_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Released line rests high through its pull-up
	initial wire_o = 1'b1;

	// one wire, MSB first
	// Each bit opens with a fall; 19 cycles keeps well inside the time-out
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk_sys_i);
			wire_o <= 1'b0;
			repeat (b[i] ? 4 : 16) @(posedge clk_sys_i);
			wire_o <= 1'b1;
			repeat (b[i] ? 14 : 2) @(posedge clk_sys_i);
		end
	endtask

	// enable by byte write
	// Odd address, so the bit travels in the low data byte
	task automatic write_enable();
		send_byte(qtd_pkg::CMD_WRITE_MAP_BYTE);
		send_byte(qtd_pkg::FW_ENABLE_ADDR[15:8]);
		send_byte(qtd_pkg::FW_ENABLE_ADDR[7:0]);
		send_byte(8'h00);
		send_byte(8'h80);
	endtask
endmodule

/* File: test_qtd_top.sv */
// Self-checking bench for the queue status and debug entry block
module test_qtd_top;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        clk_sys_i, rst_i, done, dead, bnd, tag, ent, ext, wire_i;
	logic [1:0]  move, start, pins;
	logic [15:0] data, addr;
	logic        wire_o, wire_oe, e_clk, starved, fw_en, bg, fw_ok;
	logic        map_sel, tag_hold, hold, freeze, host_wire;
	logic [7:0]  opcode;
	int          num_errors = 0;
	int          n_checks = 0;
	int          cycles = 0;

	// Wire level: low when either party pulls it low
	assign wire_i = (wire_oe && !wire_o) ? 1'b0 : host_wire;

	qtd_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cpu_move_i(move),
		.cpu_start_i(start), .cpu_instr_done_i(done), .cpu_bus_data_i(data),
		.cpu_addr_i(addr), .cpu_dead_cycle_i(dead), .instr_boundary_i(bnd),
		.tag_hit_i(tag), .enter_debug_instruction_i(ent), .exit_debug_i(ext),
		.debug_wire_pin_i(wire_i), .debug_wire_pin_o(wire_o),
		.debug_wire_pin_oe_o(wire_oe), .bus_phase_clock_o(e_clk),
		.queue_status_pins_o(pins), .opcode_o(opcode), .queue_starved_o(starved),
		.firmware_enable_bit_o(fw_en), .background_debug_state_o(bg),
		.firmware_cmd_ok_o(fw_ok), .debug_map_sel_o(map_sel), .tag_hold_o(tag_hold),
		.cpu_hold_o(hold), .freeze_cpu_o(freeze));

	qtd_host_model i_host (.clk_sys_i(clk_sys_i), .wire_o(host_wire));

	// ----------------------------------------------------------------
	// Clock, hang guard and shared tasks
	// ----------------------------------------------------------------
	initial clk_sys_i = 1'b0;
	always #25 clk_sys_i = ~clk_sys_i;

	// Whole run needs about 2000 cycles; two and a half times that means a hang
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Waits for E to pass through the other level into lvl
	task automatic wait_e(input logic lvl);
		int n;
		n = 0;
		// Step off the edge so E is read settled
		#1;
		while (e_clk === lvl && n < 8) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		while (e_clk !== lvl && n < 16) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
	endtask

	task automatic leave();
		@(posedge clk_sys_i);
		ext <= 1'b1;
		@(posedge clk_sys_i);
		ext <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk("bg after exit", 16'h0000, {15'h0, bg});
		chk("map after exit", 16'h0000, {15'h0, map_sel});
		chk("fw cmd after exit", 16'h0000, {15'h0, fw_ok});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_pins();
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			@(posedge clk_sys_i);
			move <= c;
			start <= c;
			wait_e(1'b1);
			wait_e(1'b0);
			chk("move code", 16'(c), 16'(pins));
			wait_e(1'b1);
			chk("start code", 16'(c), 16'(pins));
		end
		$display("test pins done");
	endtask

	// Every queue word equal, so the byte picked depends only on parity
	task automatic test_opcode();
		@(posedge clk_sys_i);
		data <= 16'hA1B2;
		move <= qtd_pkg::MOVE_ADV_BUS;
		start <= qtd_pkg::START_NONE;
		repeat (16) @(posedge clk_sys_i);
		move <= qtd_pkg::MOVE_NONE;
		start <= qtd_pkg::START_EVEN;
		repeat (12) @(posedge clk_sys_i);
		#1;
		chk("even opcode", 16'h00A1, 16'(opcode));
		chk("starved", 16'h0000, {15'h0, starved});
		@(posedge clk_sys_i);
		start <= qtd_pkg::START_ODD;
		repeat (12) @(posedge clk_sys_i);
		#1;
		chk("odd opcode", 16'h00B2, 16'(opcode));
		@(posedge clk_sys_i);
		start <= qtd_pkg::START_NONE;
		$display("test opcode done");
	endtask

	task automatic test_deny();
		int cnt;
		cnt = 0;
		@(posedge clk_sys_i);
		ent <= 1'b1;
		repeat (14) begin
			@(posedge clk_sys_i);
			ent <= 1'b0;
			#1;
			cnt += int'(hold === 1'b1);
		end
		chk("hold cycles", 16'(qtd_pkg::DENY_DELAY_CYC), 16'(cnt));
		chk("bg denied", 16'h0000, {15'h0, bg});
		$display("test deny done");
	endtask

	task automatic test_enable();
		i_host.write_enable();
		repeat (4) @(posedge clk_sys_i);
		#1;
		chk("fw enable", 16'h0001, {15'h0, fw_en});
		$display("test enable done");
	endtask

	task automatic test_tag();
		@(posedge clk_sys_i);
		addr <= 16'hFF05;
		tag <= 1'b1;
		@(posedge clk_sys_i);
		tag <= 1'b0;
		#1;
		chk("bg by tag", 16'h0001, {15'h0, bg});
		chk("tag hold", 16'h0001, {15'h0, tag_hold});
		chk("fw cmd ok", 16'h0001, {15'h0, fw_ok});
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk("map sel", 16'h0001, {15'h0, map_sel});
		leave();
		$display("test tag done");
	endtask

	task automatic test_instr();
		@(posedge clk_sys_i);
		ent <= 1'b1;
		@(posedge clk_sys_i);
		ent <= 1'b0;
		#1;
		chk("bg by instr", 16'h0001, {15'h0, bg});
		leave();
		$display("test instr done");
	endtask

	task automatic test_cmd();
		i_host.send_byte(qtd_pkg::CMD_BACKGROUND);
		repeat (20) @(posedge clk_sys_i);
		#1;
		chk("bg pending", 16'h0000, {15'h0, bg});
		@(posedge clk_sys_i);
		bnd <= 1'b1;
		@(posedge clk_sys_i);
		bnd <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk("bg at boundary", 16'h0001, {15'h0, bg});
		leave();
		$display("test cmd done");
	endtask

	// A start while the last instruction runs is shown as no start
	task automatic test_busy();
		wait_e(1'b0);
		@(posedge clk_sys_i);
		done <= 1'b0;
		start <= qtd_pkg::START_EVEN;
		wait_e(1'b1);
		chk("first start", 16'(qtd_pkg::START_EVEN), 16'(pins));
		wait_e(1'b1);
		chk("start while busy", 16'(qtd_pkg::START_NONE), 16'(pins));
		@(posedge clk_sys_i);
		done <= 1'b1;
		wait_e(1'b1);
		chk("start after done", 16'(qtd_pkg::START_EVEN), 16'(pins));
		@(posedge clk_sys_i);
		start <= qtd_pkg::START_NONE;
		$display("test busy done");
	endtask

	// No free bus cycle: the write waits, then exactly one cycle is stolen
	task automatic test_steal();
		int   pulses;
		logic en_mid;
		pulses = 0;
		en_mid = 1'b0;
		@(posedge clk_sys_i);
		dead <= 1'b0;
		i_host.send_byte(qtd_pkg::CMD_WRITE_MAP_BYTE);
		i_host.send_byte(qtd_pkg::FW_ENABLE_ADDR[15:8]);
		i_host.send_byte(qtd_pkg::FW_ENABLE_ADDR[7:0]);
		i_host.send_byte(8'h00);
		i_host.send_byte(8'h00);
		for (int j = 1; j <= 200; j++) begin
			@(posedge clk_sys_i);
			#1;
			pulses += int'(freeze === 1'b1);
			if (j == 100) begin
				en_mid = fw_en;
			end
		end
		chk("enable before steal", 16'h0001, {15'h0, en_mid});
		chk("steal pulses", 16'h0001, 16'(pulses));
		chk("enable cleared", 16'h0000, {15'h0, fw_en});
		chk("wire never driven", 16'h0000, {14'h0, wire_oe, wire_o});
		@(posedge clk_sys_i);
		dead <= 1'b1;
		$display("test steal done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_i, done, dead} = 3'h7;
		{bnd, tag, ent, ext} = 4'h0;
		{move, start} = 4'h0;
		data = 16'h0000;
		addr = 16'h0000;
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1;
		chk("pins in reset", 16'h0000, 16'(pins));
		test_pins();
		test_opcode();
		test_busy();
		test_deny();
		test_enable();
		test_tag();
		test_instr();
		test_cmd();
		test_steal();
		complete_run();
	end
endmodule
